// File: verilog/adc_status_mode_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "adc_regs_consts.vh"
// two-stage synchroniser; nothing but the second stage may be read
module sync_2ff #(
  parameter RESET_VAL = 1'h0
) (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire async_i,
  output wire sync_o
);
  reg meta_r;
  reg sync_r;

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule

// sticky flag; a set in the same cycle as a clear wins so that
// no event is lost to a host write or a conversion start
module sticky_flag #(
  parameter RESET_VAL = 1'h0
) (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire set_i,
  input wire clr_i,
  output wire flag_o
);
  reg flag_r;
  reg flag_nxt;

  always @* begin
    flag_nxt = flag_r;
    if (set_i) begin
      flag_nxt = 1'h1;
    end else if (clr_i) begin
      flag_nxt = 1'h0;
    end
  end

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_r <= RESET_VAL;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag_o = flag_r;
endmodule

module adc_status_mode_regs (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire cmd_valid_i,
  input wire [7:0] cmd_byte_i,
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [4:0] addr_i,
  input wire [7:0] wdata_i,
  input wire crc_mismatch_i,
  input wire amp_low_i,
  input wire amp_high_i,
  input wire vref_low_i,
  input wire conv_start_i,
  input wire sample_update_i,
  input wire data_read_i,
  input wire ext_clock_i,
  output reg [7:0] rdata_o,
  output wire write_blocked_o,
  output wire [4:0] rate_select_o,
  output wire [4:0] rate_index_o,
  output wire [2:0] filter_select_o,
  output wire filter_reserved_o,
  output wire [1:0] polarity_swap_select_o,
  output wire one_shot_select_o,
  output wire [3:0] delay_select_o,
  output wire ext_clock_o
);
  reg lock_r;
  reg lock_nxt;
  reg [7:0] rate_filter_r;
  reg [7:0] rate_filter_nxt;
  reg [7:0] conv_ctrl_r;
  reg [7:0] conv_ctrl_nxt;
  reg [7:0] rdata_nxt;
  wire amp_low_s;
  wire amp_high_s;
  wire vref_low_s;
  wire ext_clk_s;
  wire check_err_w;
  wire amp_under_w;
  wire amp_over_w;
  wire vref_under_w;
  wire new_sample_w;
  wire reset_seen_w;
  wire wr_ok;
  wire status_wr;
  wire check_err_clr;
  wire reset_seen_clr;
  wire [7:0] status_w;

  // analog comparator levels come from another domain
  sync_2ff #(.RESET_VAL(`FLAG_INIT)) u_sync_amp_low (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .async_i(amp_low_i),
    .sync_o(amp_low_s)
  );

  sync_2ff #(.RESET_VAL(`FLAG_INIT)) u_sync_amp_high (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .async_i(amp_high_i),
    .sync_o(amp_high_s)
  );

  sync_2ff #(.RESET_VAL(`FLAG_INIT)) u_sync_vref_low (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .async_i(vref_low_i),
    .sync_o(vref_low_s)
  );

  // clock detect level is asynchronous as well
  sync_2ff #(.RESET_VAL(`FLAG_INIT)) u_sync_ext_clk (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .async_i(ext_clock_i),
    .sync_o(ext_clk_s)
  );

  // lock blocks writes
  // a write beside a command still sees the old lock state
  assign wr_ok = wr_en_i & ~lock_r;
  assign status_wr = wr_ok & (addr_i == `ADDR_STATUS);

  always @* begin
    lock_nxt = lock_r;
    if (cmd_valid_i) begin
      if (cmd_byte_i == `CMD_WRITE_BLOCK) begin
        lock_nxt = 1'h1;
      end else if (cmd_byte_i == `CMD_WRITE_PERMIT) begin
        lock_nxt = 1'h0;
      end
    end
  end

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_r <= `LOCK_RESET;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  // sticky; only a written 0 clears it
  assign check_err_clr = status_wr & ~wdata_i[`BIT_CHECK_ERR];
  sticky_flag #(.RESET_VAL(`FLAG_INIT)) u_check_err (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .set_i(crc_mismatch_i),
    .clr_i(check_err_clr),
    .flag_o(check_err_w)
  );

  assign reset_seen_clr = status_wr & ~wdata_i[`BIT_RESET_SEEN];
  sticky_flag #(.RESET_VAL(`RESET_SEEN_INIT)) u_reset_seen (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .set_i(1'h0),
    .clr_i(reset_seen_clr),
    .flag_o(reset_seen_w)
  );

  sticky_flag #(.RESET_VAL(`FLAG_INIT)) u_amp_under (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .set_i(amp_low_s),
    .clr_i(conv_start_i),
    .flag_o(amp_under_w)
  );

  sticky_flag #(.RESET_VAL(`FLAG_INIT)) u_amp_over (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .set_i(amp_high_s),
    .clr_i(conv_start_i),
    .flag_o(amp_over_w)
  );

  sticky_flag #(.RESET_VAL(`FLAG_INIT)) u_vref_under (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .set_i(vref_low_s),
    .clr_i(conv_start_i),
    .flag_o(vref_under_w)
  );

  // new data since last data read; status reads keep it
  sticky_flag #(.RESET_VAL(`FLAG_INIT)) u_new_sample (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .set_i(sample_update_i),
    .clr_i(data_read_i),
    .flag_o(new_sample_w)
  );

  always @* begin
    rate_filter_nxt = rate_filter_r;
    conv_ctrl_nxt = conv_ctrl_r;
    if (wr_ok && addr_i == `ADDR_RATE_FILTER) begin
      rate_filter_nxt = wdata_i;
    end
    if (wr_ok && addr_i == `ADDR_CONV_CTRL) begin
      conv_ctrl_nxt = wdata_i & `CONV_CTRL_WMASK;
    end
  end

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rate_filter_r <= `RATE_FILTER_RESET;
      conv_ctrl_r <= `CONV_CTRL_RESET;
    end else begin
      rate_filter_r <= rate_filter_nxt;
      conv_ctrl_r <= conv_ctrl_nxt;
    end
  end

  // lock and clock source into status
  assign status_w = {lock_r, check_err_w, amp_under_w, amp_over_w,
                     vref_under_w, new_sample_w, ext_clk_s,
                     reset_seen_w};

  // read mux; unmapped reads return zero
  always @* begin
    rdata_nxt = rdata_o;
    if (rd_en_i) begin
      case (addr_i)
        `ADDR_STATUS: begin
          rdata_nxt = status_w;
        end
        `ADDR_RATE_FILTER: begin
          rdata_nxt = rate_filter_r;
        end
        `ADDR_CONV_CTRL: begin
          rdata_nxt = conv_ctrl_r;
        end
        default: begin
          rdata_nxt = `RDATA_UNMAPPED;
        end
      endcase
    end
  end

  // registered so the answer stands until the next read
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= `RDATA_RESET;
    end else begin
      rdata_o <= rdata_nxt;
    end
  end

  assign write_blocked_o = lock_r;
  assign rate_select_o = rate_filter_r[`RATE_MSB:`RATE_LSB];
  assign rate_index_o = rate_select_o[`RATE_FASTEST_BIT] ?
                        `RATE_FASTEST_CODE : rate_select_o;
  assign filter_select_o = rate_filter_r[`FILT_MSB:`FILT_LSB];
  assign filter_reserved_o = filter_select_o > `FILT_LAST_VALID;
  assign polarity_swap_select_o = conv_ctrl_r[`POL_MSB:`POL_LSB];
  assign one_shot_select_o = conv_ctrl_r[`ONE_SHOT_BIT];
  assign delay_select_o = conv_ctrl_r[`DELAY_MSB:`DELAY_LSB];
  assign ext_clock_o = ext_clk_s;
endmodule
`default_nettype wire

// File: verilog/adc_regs_consts.vh
`ifndef ADC_REGS_CONSTS_VH
`define ADC_REGS_CONSTS_VH
`define ADDR_STATUS 5'h01
`define ADDR_RATE_FILTER 5'h02
`define ADDR_CONV_CTRL 5'h03
`define CMD_WRITE_BLOCK 8'hF2
`define CMD_WRITE_PERMIT 8'hF5
`define BIT_LOCK 7
`define BIT_CHECK_ERR 6
`define BIT_AMP_UNDER 5
`define BIT_AMP_OVER 4
`define BIT_VREF_UNDER 3
`define BIT_NEW_SAMPLE 2
`define BIT_CLOCK_SRC 1
`define BIT_RESET_SEEN 0
`define RATE_FILTER_RESET 8'h24
`define CONV_CTRL_RESET 8'h01
`define CONV_CTRL_WMASK 8'h7F
`define RATE_MSB 7
`define RATE_LSB 3
`define FILT_MSB 2
`define FILT_LSB 0
`define RATE_FASTEST_BIT 4
`define RATE_FASTEST_CODE 5'h10
`define FILT_FIR 3'h4
`define FILT_LAST_VALID 3'h4
`define POL_MSB 6
`define POL_LSB 5
`define ONE_SHOT_BIT 4
`define DELAY_MSB 3
`define DELAY_LSB 0
`define LOCK_RESET 1'h0
`define FLAG_INIT 1'h0
`define RESET_SEEN_INIT 1'h1
`define RDATA_RESET 8'h00
`define RDATA_UNMAPPED 8'h00
`endif

// File: dv/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire clk_sys_i,
  output logic cmd_valid_i,
  output logic [7:0] cmd_byte_i,
  output logic wr_en_i,
  output logic rd_en_i,
  output logic [4:0] addr_i,
  output logic [7:0] wdata_i
);
  initial {cmd_valid_i, cmd_byte_i, wr_en_i, rd_en_i, addr_i, wdata_i} = '0;
  // locks and clears
  // k: 2 command, 1 write, 0 read; an idle bus shows inverted data
  task automatic op(input int k, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) #1;
    {cmd_valid_i, wr_en_i, rd_en_i} = 3'h1 << k;
    addr_i = a;
    wdata_i = d;
    cmd_byte_i = d;
    @(posedge clk_sys_i) #1;
    {cmd_valid_i, wr_en_i, rd_en_i} = 3'h0;
    {addr_i, wdata_i, cmd_byte_i} = ~{addr_i, wdata_i, cmd_byte_i};
  endtask
endmodule
`default_nettype wire

// File: dv/adc_status_mode_regs_chk.sv
`timescale 1ns/100ps
`default_nettype none
module regs_chk (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire cmd_valid_i,
  input wire [7:0] cmd_byte_i,
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [4:0] addr_i,
  input wire [7:0] wdata_i,
  input wire [7:0] rdata_o,
  input wire write_blocked_o,
  input wire [4:0] rate_select_o,
  input wire [4:0] rate_index_o,
  input wire [2:0] filter_select_o,
  input wire filter_reserved_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  lock_set_a: assert property (
    cmd_valid_i && cmd_byte_i == 8'hF2 |=> write_blocked_o) else $error("lock");
  write_hold_a: assert property (
    write_blocked_o && wr_en_i |=> $stable({rate_select_o, filter_select_o}))
    else $error("locked write");
  rate_write_a: assert property (
    wr_en_i && !write_blocked_o && addr_i == 5'h02
    |=> {rate_select_o, filter_select_o} == $past(wdata_i)) else $error("wr");
  rate_fold_a: assert property (
    rate_index_o == (rate_select_o[4] ? 5'h10 : rate_select_o)) else $error("f");
  filt_rsvd_a: assert property (
    filter_reserved_o == (filter_select_o > 3'h4)) else $error("rsvd");
  cfg_read_a: assert property (
    rd_en_i && addr_i == 5'h02
    |=> rdata_o == $past({rate_select_o, filter_select_o})) else $error("rd");
  lock_bit_a: assert property (
    rd_en_i && addr_i == 5'h01 |=> rdata_o[7] == $past(write_blocked_o))
    else $error("lock bit");
  ctrl_rsvd_a: assert property (
    rd_en_i && addr_i == 5'h03 |=> !rdata_o[7]) else $error("ctrl bit7");
  cover property (write_blocked_o && wr_en_i);
  cover property (rd_en_i && addr_i == 5'h01);
  cover property (filter_reserved_o);
endmodule
bind adc_status_mode_regs regs_chk u_chk (.clk_sys_i, .rstn_i, .cmd_valid_i,
  .cmd_byte_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i, .rdata_o,
  .write_blocked_o, .rate_select_o, .rate_index_o, .filter_select_o,
  .filter_reserved_o);
`default_nettype wire

// File: dv/adc_status_mode_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
module adc_status_mode_regs_test;
  logic clk_sys_i = 0, rstn_i = 0, crc_mismatch_i = 0, conv_start_i = 0;
  logic amp_low_i = 0, amp_high_i = 0, vref_low_i = 0, ext_clock_i = 0;
  logic sample_update_i = 0, data_read_i = 0, cmd_valid_i, wr_en_i, rd_en_i;
  logic [7:0] cmd_byte_i, wdata_i, rdata_o;
  logic [4:0] addr_i, rate_select_o, rate_index_o;
  logic [2:0] filter_select_o;
  logic write_blocked_o, filter_reserved_o;
  logic [1:0] polarity_swap_select_o;
  logic [3:0] delay_select_o;
  logic one_shot_select_o, ext_clock_o;
  int bad_count = 0, comparisons = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  host_model h (.clk_sys_i, .cmd_valid_i, .cmd_byte_i, .wr_en_i, .rd_en_i,
    .addr_i, .wdata_i);
  adc_status_mode_regs dut (.clk_sys_i, .rstn_i, .cmd_valid_i, .cmd_byte_i,
    .wr_en_i, .rd_en_i, .addr_i, .wdata_i, .crc_mismatch_i, .amp_low_i,
    .amp_high_i, .vref_low_i, .conv_start_i, .sample_update_i, .data_read_i,
    .ext_clock_i, .rdata_o, .write_blocked_o, .rate_select_o, .rate_index_o,
    .filter_select_o, .filter_reserved_o, .polarity_swap_select_o,
    .one_shot_select_o, .delay_select_o, .ext_clock_o);
  task automatic chk(input string n, input logic [7:0] s, e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    h.op(0, a, 8'h00);
    chk("rdata", rdata_o, e);
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk_sys_i) #1 s = 1;
    @(posedge clk_sys_i) #1 s = 0;
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000 bad_count++;
    summarize;
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    #1 rstn_i = 1;
    rc(5'h01, 8'h01);
    rc(5'h03, 8'h01);
    rc(5'h1F, 8'h00);
    for (int i = 0; i < 256; i++) begin
      h.op(1, 5'h02, 8'(i));
      chk("index", rate_index_o, i[7] ? 8'h10 : 8'(i[7:3]));
      chk("rsvd", filter_reserved_o, i[2:0] > 4);
      rc(5'h02, 8'(i));
    end
    h.op(2, 5'h00, 8'hF2);
    h.op(1, 5'h02, 8'h00);
    rc(5'h02, 8'hFF);
    rc(5'h01, 8'h81);
    chk("blocked", write_blocked_o, 8'h01);
    h.op(2, 5'h00, 8'hF5);
    h.op(1, 5'h01, 8'hFF);
    rc(5'h01, 8'h01);
    chk("blocked", write_blocked_o, 8'h00);
    pulse(crc_mismatch_i);
    rc(5'h01, 8'h41);
    h.op(1, 5'h01, 8'h40);
    rc(5'h01, 8'h40);
    h.op(1, 5'h01, 8'h00);
    rc(5'h01, 8'h00);
    {amp_low_i, amp_high_i, vref_low_i} = 3'h7;
    repeat (4) @(posedge clk_sys_i);
    #1 {amp_low_i, amp_high_i, vref_low_i} = 3'h0;
    rc(5'h01, 8'h38);
    pulse(conv_start_i);
    rc(5'h01, 8'h00);
    pulse(sample_update_i);
    rc(5'h01, 8'h04);
    pulse(data_read_i);
    rc(5'h01, 8'h00);
    ext_clock_i = 1;
    repeat (4) @(posedge clk_sys_i);
    rc(5'h01, 8'h02);
    chk("clksrc", ext_clock_o, 8'h01);
    h.op(1, 5'h03, 8'hFF);
    rc(5'h03, 8'h7F);
    chk("polarity", polarity_swap_select_o, 8'h03);
    chk("oneshot", one_shot_select_o, 8'h01);
    chk("delay", delay_select_o, 8'h0F);
    ext_clock_i = 0;
    rstn_i = 0;
    repeat (3) @(posedge clk_sys_i);
    #1 rstn_i = 1;
    rc(5'h01, 8'h01);
    rc(5'h02, 8'h24);
    chk("delay", delay_select_o, 8'h01);
    chk("oneshot", one_shot_select_o, 8'h00);
    chk("polarity", polarity_swap_select_o, 8'h00);
    chk("clksrc", ext_clock_o, 8'h00);
    summarize;
  end
endmodule
`default_nettype wire
